/* hw/measurement_timer_pkg.sv */
// Purpose: Shared constants and mode encoding for the measurement timer
// Assumes: Single 200 MHz clock domain
// Notes: Flag indices order the interrupt vectors
package measurement_timer_pkg;
	localparam int CNT_W = 24;
	localparam logic [23:0] COUNT_RESET = 24'h000000;
	localparam logic [23:0] PERIOD_DUTY_RELOAD = 24'h000001;
	localparam int FLAG_N = 3;
	localparam int FLAG_WIDTH = 0;
	localparam int FLAG_PERIOD = 1;
	localparam int FLAG_MATCH = 2;
	localparam logic RESET_LOW = 1'b0;

	typedef enum logic [3:0] {
		MODE_TIMER = 4'h0,
		MODE_GATED_TIMER = 4'h1,
		MODE_PERIOD_DUTY = 4'h2,
		MODE_HIGH_LOW = 4'h3,
		MODE_WINDOWED = 4'h4,
		MODE_GATED_WINDOWED = 4'h5,
		MODE_TIME_OF_FLIGHT = 4'h6,
		MODE_CAPTURE = 4'h7,
		MODE_COUNTER = 4'h8,
		MODE_GATED_COUNTER = 4'h9,
		MODE_WINDOWED_COUNTER = 4'ha
	} mode_t;
endpackage

/* hw/measurement_timer.sv */
// Purpose: Mode logic of a 24-bit signal measurement timer
// Assumes: timer_tick_in is a prescaled one-cycle enable on clk_in; pins are asynchronous
// Notes: Counter modes count synchronised signal edges, so pulses must be wider than one clock
//
// Summary of operation
// R01: Timer mode counts while running, captures nothing, all on timer clock.
// R02: Timer mode ignores window and signal edges for the run request.
// R03: Counter equal to period limit on an increment resets counter (held instead if halt set) and raises period match flag.
// R04: Gated timer counts while signal active; falling edge captures pulse width.
// R05: Period/duty: each rise reloads one; after the first rise, fall captures width and rise captures period.
// R06: Period/duty single acquisition clears run request on completing rising edge.
// R07: High/low: rise starts counting; fall captures width, clears, keeps counting.
// R08: High/low: next rise captures period, clears counter, resumes counting.
// R09: Windowed: first window rise starts; next rise captures period, resets.
// R10: Gated windowed: after first window rise count while signal active; later window rises capture period.
// R11: Time of flight: window rise starts; signal rise captures period, resets.
// R12: Time of flight: two window rises without signal rise capture width, reset.
// R13: Capture: count when running; window rise captures period, fall captures width.
// R14: Capture: only software or a period match without halt clears the counter.
// R15: Counter mode increments on each signal pulse, not timer clock.
// R16: Counter mode captures width on each falling window edge.
// R17: Gated counter counts from window rise; window fall captures width.
// R18: Windowed counter: fall captures width; later window rises capture period.
// R19: Width acquisition flag set whenever width capture updates.
// R20: Period acquisition flag set whenever period capture updates.
// R21: Period match flag on limit; each flag maskable by its enable.
// R22: Keeps running whenever its clock and inputs keep running.
// R23: Single acquisition stops and clears run request; repeat keeps overwriting.
// R24: On match counter holds at limit if halt set, else resets zero.
// R25: Separate polarity for signal and window swaps edges and active level.
// R26: Signal and window pass two-stage synchronisers; run request is delayed two stages except in counter modes.
// R27: Disabled block stops counter, clears tracking, no captures or flags.
module measurement_timer #(
	parameter int CNT_W = measurement_timer_pkg::CNT_W
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic enable_in,
	input wire logic [3:0] mode_in,
	input wire logic repeat_in,
	input wire logic halt_at_match_in,
	input wire logic signal_polarity_in,
	input wire logic window_polarity_in,
	input wire logic run_request_set_in,
	input wire logic run_request_clr_in,
	input wire logic counter_clear_in,
	input wire logic [CNT_W-1:0] period_limit_in,
	input wire logic timer_tick_in,
	input wire logic signal_input_in,
	input wire logic window_input_in,
	input wire logic [2:0] peripheral_irq_enable_in,
	input wire logic [2:0] flag_clear_in,
	output logic [CNT_W-1:0] measure_counter_out,
	output logic [CNT_W-1:0] pulse_width_capture_out,
	output logic [CNT_W-1:0] period_capture_out,
	output logic run_request_out,
	output logic timer_status_out,
	output logic signal_status_out,
	output logic window_status_out,
	output logic width_acq_flag_out,
	output logic period_acq_flag_out,
	output logic period_match_flag_out,
	output logic width_acq_irq_out,
	output logic period_acq_irq_out,
	output logic period_match_irq_out
);
	logic sig_s1_q, sig_s2_q, win_s1_q, win_s2_q;
	logic go_s1_q, go_s2_q;
	logic sig_prev_q, win_prev_q;
	logic run_q, armed_q, wait_q;
	logic [CNT_W-1:0] cnt_q, cnt_d, cpw_q, cpr_q;
	logic [2:0] flag_q, flag_set;
	logic sig_act, win_act, sig_rise, sig_fall, win_rise, win_fall;
	logic counter_mode, active, tick;
	logic inc, load_en, cpw_ld, cpr_ld, done, arm_set, wait_set, wait_clr, match_ev;
	logic [CNT_W-1:0] load_val;

	// Pins are asynchronous; first stage feeds only the second
	// Run request delayed to line up with the synchronised inputs
	always_ff @(posedge clk_in) begin // [R26]
		if (rstn_in == measurement_timer_pkg::RESET_LOW) begin
			sig_s1_q <= 1'b0;
			sig_s2_q <= 1'b0;
			win_s1_q <= 1'b0;
			win_s2_q <= 1'b0;
			go_s1_q <= 1'b0;
			go_s2_q <= 1'b0;
			sig_prev_q <= 1'b0;
			win_prev_q <= 1'b0;
		end else begin
			sig_s1_q <= signal_input_in;
			sig_s2_q <= sig_s1_q;
			win_s1_q <= window_input_in;
			win_s2_q <= win_s1_q;
			go_s1_q <= run_q;
			go_s2_q <= go_s1_q;
			sig_prev_q <= sig_act;
			win_prev_q <= win_act;
		end
	end

	assign sig_act = sig_s2_q ^ signal_polarity_in; // [R25]
	assign win_act = win_s2_q ^ window_polarity_in; // [R25]

	assign sig_rise = sig_act & ~sig_prev_q;
	assign sig_fall = ~sig_act & sig_prev_q;
	assign win_rise = win_act & ~win_prev_q;
	assign win_fall = ~win_act & win_prev_q;

	assign counter_mode = (mode_in == measurement_timer_pkg::MODE_COUNTER) ||
		(mode_in == measurement_timer_pkg::MODE_GATED_COUNTER) ||
		(mode_in == measurement_timer_pkg::MODE_WINDOWED_COUNTER);
	// Counter modes skip the run-request delay, as they have no timer clock
	assign active = enable_in & (counter_mode ? run_q : go_s2_q); // [R27]
	// Signal edges are the time base in counter modes
	assign tick = counter_mode ? sig_rise : timer_tick_in; // [R15] [R22]

	always_comb begin
		inc = 1'b0;
		load_en = 1'b0;
		load_val = measurement_timer_pkg::COUNT_RESET;
		cpw_ld = 1'b0;
		cpr_ld = 1'b0;
		done = 1'b0;
		arm_set = 1'b0;
		wait_set = 1'b0;
		wait_clr = 1'b0;
		if (active) begin
			case (mode_in)
				measurement_timer_pkg::MODE_TIMER: begin
					inc = tick; // [R01] [R02]
				end
				measurement_timer_pkg::MODE_GATED_TIMER: begin
					inc = tick & sig_act; // [R04]
					if (sig_fall) begin
						cpw_ld = 1'b1; // [R04]
						done = 1'b1;
					end
				end
				measurement_timer_pkg::MODE_PERIOD_DUTY: begin
					inc = tick;
					if (sig_fall && armed_q) begin
						cpw_ld = 1'b1; // [R05]
					end
					if (sig_rise) begin
						load_en = 1'b1; // [R05]
						load_val = measurement_timer_pkg::PERIOD_DUTY_RELOAD;
						arm_set = 1'b1;
						cpr_ld = armed_q;
						done = armed_q; // [R06]
					end
				end
				measurement_timer_pkg::MODE_HIGH_LOW: begin
					inc = tick & armed_q; // [R07]
					if (sig_fall && armed_q) begin
						cpw_ld = 1'b1; // [R07]
						load_en = 1'b1;
					end
					if (sig_rise) begin
						load_en = 1'b1; // [R08]
						arm_set = 1'b1;
						cpr_ld = armed_q;
						done = armed_q;
					end
				end
				measurement_timer_pkg::MODE_WINDOWED, measurement_timer_pkg::MODE_GATED_WINDOWED: begin
					if (mode_in == measurement_timer_pkg::MODE_WINDOWED) begin
						inc = tick & armed_q; // [R09]
					end else begin
						inc = tick & armed_q & sig_act; // [R10]
					end
					if (win_rise) begin
						load_en = armed_q; // [R09] [R10]
						cpr_ld = armed_q;
						done = armed_q;
						arm_set = 1'b1;
					end
				end
				measurement_timer_pkg::MODE_TIME_OF_FLIGHT: begin
					inc = tick & wait_q; // [R11]
					if (win_rise) begin
						load_en = 1'b1; // [R11]
						cpw_ld = wait_q; // [R12]
						wait_set = 1'b1;
					end
					// A coincident signal edge takes the period result
					if (sig_rise && wait_q) begin
						load_en = 1'b1; // [R11]
						cpw_ld = 1'b0;
						cpr_ld = 1'b1;
						done = 1'b1;
						wait_clr = ~win_rise;
					end
				end
				measurement_timer_pkg::MODE_CAPTURE: begin
					inc = tick; // [R13] [R14]
					cpr_ld = win_rise; // [R13]
					cpw_ld = win_fall; // [R13]
					done = win_fall;
				end
				measurement_timer_pkg::MODE_COUNTER: begin
					inc = tick; // [R15]
					cpw_ld = win_fall; // [R16]
					done = win_fall;
				end
				measurement_timer_pkg::MODE_GATED_COUNTER: begin
					inc = tick & armed_q & win_act; // [R17]
					arm_set = win_rise;
					if (win_fall && armed_q) begin
						cpw_ld = 1'b1; // [R17]
						done = 1'b1;
					end
				end
				measurement_timer_pkg::MODE_WINDOWED_COUNTER: begin
					inc = tick & armed_q; // [R18]
					cpw_ld = win_fall & armed_q; // [R18]
					if (win_rise) begin
						load_en = armed_q; // [R18]
						cpr_ld = armed_q;
						done = armed_q;
						arm_set = 1'b1;
					end
				end
				default: begin
					inc = 1'b0;
				end
			endcase
		end
	end

	assign match_ev = ~counter_clear_in & ~load_en & inc & (cnt_q == period_limit_in); // [R03]

	always_comb begin
		cnt_d = cnt_q;
		if (counter_clear_in) begin
			cnt_d = measurement_timer_pkg::COUNT_RESET; // [R14]
		end else if (load_en) begin
			cnt_d = load_val;
		end else if (match_ev) begin
			cnt_d = halt_at_match_in ? cnt_q : measurement_timer_pkg::COUNT_RESET; // [R24] [R03]
		end else if (inc) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rstn_in == measurement_timer_pkg::RESET_LOW) begin
			cnt_q <= measurement_timer_pkg::COUNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rstn_in == measurement_timer_pkg::RESET_LOW) begin
			cpw_q <= measurement_timer_pkg::COUNT_RESET;
			cpr_q <= measurement_timer_pkg::COUNT_RESET;
		end else begin
			if (cpw_ld) begin
				cpw_q <= cnt_q; // [R04] [R16]
			end
			if (cpr_ld) begin
				cpr_q <= cnt_q; // [R13]
			end
		end
	end

	// Tracking state is dropped whenever acquisition is not live
	always_ff @(posedge clk_in) begin
		if (rstn_in == measurement_timer_pkg::RESET_LOW) begin
			armed_q <= 1'b0;
			wait_q <= 1'b0;
		end else if (!active) begin
			armed_q <= 1'b0; // [R27]
			wait_q <= 1'b0;
		end else begin
			armed_q <= armed_q | arm_set;
			wait_q <= wait_set | (wait_q & ~wait_clr);
		end
	end

	// Software set wins over any completion clear
	always_ff @(posedge clk_in) begin
		if (rstn_in == measurement_timer_pkg::RESET_LOW) begin
			run_q <= 1'b0;
		end else if (run_request_set_in) begin
			run_q <= 1'b1;
		end else if (run_request_clr_in || (done && !repeat_in)) begin
			run_q <= 1'b0; // [R23] [R06]
		end
	end

	assign flag_set[measurement_timer_pkg::FLAG_WIDTH] = cpw_ld; // [R19]
	assign flag_set[measurement_timer_pkg::FLAG_PERIOD] = cpr_ld; // [R20]
	assign flag_set[measurement_timer_pkg::FLAG_MATCH] = match_ev; // [R21]

	// Hardware set beats a same-cycle software clear
	for (genvar i = 0; i < measurement_timer_pkg::FLAG_N; i++) begin : g_flag
		always_ff @(posedge clk_in) begin
			if (rstn_in == measurement_timer_pkg::RESET_LOW) begin
				flag_q[i] <= 1'b0;
			end else if (flag_set[i]) begin
				flag_q[i] <= 1'b1; // [R19] [R20] [R21]
			end else if (flag_clear_in[i]) begin
				flag_q[i] <= 1'b0;
			end
		end
	end

	assign measure_counter_out = cnt_q;
	assign pulse_width_capture_out = cpw_q;
	assign period_capture_out = cpr_q;
	assign run_request_out = run_q;
	assign timer_status_out = active;
	assign signal_status_out = sig_act;
	assign window_status_out = win_act;
	assign width_acq_flag_out = flag_q[measurement_timer_pkg::FLAG_WIDTH];
	assign period_acq_flag_out = flag_q[measurement_timer_pkg::FLAG_PERIOD];
	assign period_match_flag_out = flag_q[measurement_timer_pkg::FLAG_MATCH];
	assign width_acq_irq_out = flag_q[0] & peripheral_irq_enable_in[0]; // [R21]
	assign period_acq_irq_out = flag_q[1] & peripheral_irq_enable_in[1]; // [R21]
	assign period_match_irq_out = flag_q[2] & peripheral_irq_enable_in[2]; // [R21]

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	property p_timer_no_capture;
		(mode_in == measurement_timer_pkg::MODE_TIMER) |-> (!cpw_ld && !cpr_ld);
	endproperty
	a_timer_no_capture: assert property (p_timer_no_capture) else $error("capture in timer mode"); // [R01]
	property p_timer_go_kept;
		(mode_in == measurement_timer_pkg::MODE_TIMER && run_q && !run_request_clr_in) |=> run_q;
	endproperty
	a_timer_go_kept: assert property (p_timer_go_kept) else $error("run request lost in timer mode"); // [R02]
	property p_match_flag;
		match_ev |=> period_match_flag_out;
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("match flag not set"); // [R03]
	property p_match_reset;
		(match_ev && !halt_at_match_in) |=> (cnt_q == measurement_timer_pkg::COUNT_RESET);
	endproperty
	a_match_reset: assert property (p_match_reset) else $error("counter not reset on match"); // [R24]
	property p_match_hold;
		(match_ev && halt_at_match_in) |=> (cnt_q == $past(period_limit_in));
	endproperty
	a_match_hold: assert property (p_match_hold) else $error("counter not held at limit"); // [R24]
	property p_width_capture;
		cpw_ld |=> (pulse_width_capture_out == $past(cnt_q)) && width_acq_flag_out;
	endproperty
	a_width_capture: assert property (p_width_capture) else $error("width capture wrong"); // [R19]
	property p_period_capture;
		cpr_ld |=> (period_capture_out == $past(cnt_q)) && period_acq_flag_out;
	endproperty
	a_period_capture: assert property (p_period_capture) else $error("period capture wrong"); // [R20]
	property p_pd_reload;
		(active && mode_in == measurement_timer_pkg::MODE_PERIOD_DUTY && sig_rise && !counter_clear_in) |=>
			(cnt_q == measurement_timer_pkg::PERIOD_DUTY_RELOAD);
	endproperty
	a_pd_reload: assert property (p_pd_reload) else $error("period duty reload wrong"); // [R05]
	property p_single_stop;
		(done && !repeat_in && !run_request_set_in) |=> !run_request_out ##1 !go_s1_q;
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("single acquisition did not stop"); // [R23]
	property p_disabled;
		!enable_in |-> (!cpw_ld && !cpr_ld && !match_ev && !inc);
	endproperty
	a_disabled: assert property (p_disabled) else $error("activity while disabled"); // [R27]

	c_pd_period: cover property (active && mode_in == measurement_timer_pkg::MODE_PERIOD_DUTY && cpr_ld);
	c_tof_overflow: cover property (mode_in == measurement_timer_pkg::MODE_TIME_OF_FLIGHT && cpw_ld);
	c_match: cover property (match_ev);
	c_single_done: cover property (done && !repeat_in);
endmodule // measurement_timer

/* test/measurement_timer_tb_top.sv */
// Purpose: Self-checking bench for the measurement timer mode logic
// Assumes: Ticks are held low while pin edges settle, so counts are exact
// Notes: Each scenario starts from setup, which disables, clears and starts the block
module measurement_timer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic en = 1'b1;
	logic [3:0] mode = 4'h0;
	logic rep = 1'b1;
	logic halt = 1'b0;
	logic sig_pol = 1'b0;
	logic win_pol = 1'b0;
	logic run_set = 1'b0;
	logic run_clr = 1'b0;
	logic cnt_clr = 1'b0;
	logic [23:0] lim = 24'hffffff;
	logic tick = 1'b0;
	logic sig = 1'b0;
	logic win = 1'b0;
	logic [2:0] irq_en = 3'h7;
	logic [2:0] flag_clr = 3'h0;
	logic [23:0] cnt;
	logic [23:0] pwc;
	logic [23:0] prc;
	logic run;
	logic w_flag;
	logic p_flag;
	logic m_flag;
	logic w_irq;
	logic p_irq;
	logic m_irq;
	logic ts;
	logic ss;
	logic ws;
	logic [23:0] hold;
	int num_errors = 0;
	int compares = 0;

	always #2.5 clk_in = ~clk_in;

	measurement_timer measurement_timer_inst (
		.clk_in(clk_in), .rstn_in(rstn_in), .enable_in(en), .mode_in(mode), .repeat_in(rep),
		.halt_at_match_in(halt), .signal_polarity_in(sig_pol), .window_polarity_in(win_pol),
		.run_request_set_in(run_set), .run_request_clr_in(run_clr), .counter_clear_in(cnt_clr),
		.period_limit_in(lim), .timer_tick_in(tick), .signal_input_in(sig), .window_input_in(win),
		.peripheral_irq_enable_in(irq_en), .flag_clear_in(flag_clr),
		.measure_counter_out(cnt), .pulse_width_capture_out(pwc), .period_capture_out(prc),
		.run_request_out(run), .timer_status_out(ts), .signal_status_out(ss), .window_status_out(ws),
		.width_acq_flag_out(w_flag), .period_acq_flag_out(p_flag), .period_match_flag_out(m_flag),
		.width_acq_irq_out(w_irq), .period_acq_irq_out(p_irq), .period_match_irq_out(m_irq)
	);

	// Wide enough for a capture and the counter side by side
	task automatic chk(input string name, input logic [47:0] got, input logic [47:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// Six clocks cover the two-stage synchroniser, detection and the load
	task automatic pins(input logic s, input logic w);
		@(posedge clk_in);
		sig <= s;
		win <= w;
		cyc(6);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk_in);
			tick <= 1'b1;
		end
		@(posedge clk_in);
		tick <= 1'b0;
		cyc(3);
	endtask

	task automatic pulses(input int n, input logic w);
		repeat (n) begin
			pins(1'b1, w);
			pins(1'b0, w);
		end
	endtask

	// Disable clears tracking state left over from the previous mode
	task automatic setup(input logic [3:0] m, input logic r);
		@(posedge clk_in);
		en <= 1'b0;
		run_clr <= 1'b1;
		flag_clr <= 3'h7;
		mode <= m;
		rep <= r;
		@(posedge clk_in);
		en <= 1'b1;
		run_clr <= 1'b0;
		flag_clr <= 3'h0;
		cnt_clr <= 1'b1;
		@(posedge clk_in);
		cnt_clr <= 1'b0;
		run_set <= 1'b1;
		@(posedge clk_in);
		run_set <= 1'b0;
		cyc(4);
		chk("run", {run, ts}, 24'h3);
	endtask

	initial begin
		cyc(12);
		rstn_in <= 1'b1;
		cyc(2);
		chk("rst cnt", cnt, 24'h0);
		chk("rst flags", {run, w_flag, p_flag, m_flag}, 24'h0);
		lim <= 24'h000005;
		setup(measurement_timer_pkg::MODE_TIMER, 1'b1);
		pins(1'b1, 1'b1);
		pins(1'b0, 1'b0);
		chk("timer run", run, 24'h1);
		chk("timer cnt", cnt, 24'h0);
		ticks(5);
		chk("timer cnt", cnt, 24'h5);
		chk("no match", m_flag, 24'h0);
		ticks(1);
		chk("wrap cnt", cnt, 24'h0);
		chk("match irq", {m_flag, m_irq}, 24'h3);
		chk("no capture", {w_flag, p_flag}, 24'h0);
		irq_en <= 3'h3;
		cyc(2);
		chk("masked irq", {m_flag, m_irq}, 24'h2);
		flag_clr <= 3'h4;
		halt <= 1'b1;
		cyc(1);
		flag_clr <= 3'h0;
		cyc(1);
		chk("cleared", m_flag, 24'h0);
		ticks(8);
		chk("halt cnt", cnt, 24'h5);
		chk("halt flag", m_flag, 24'h1);
		irq_en <= 3'h7;
		lim <= 24'hffffff;
		sig_pol <= 1'b1;
		setup(measurement_timer_pkg::MODE_GATED_TIMER, 1'b1);
		chk("sig status", ss, 24'h1);
		ticks(3);
		chk("gated cnt", cnt, 24'h3);
		pins(1'b1, 1'b0);
		ticks(2);
		chk("gated pwc", pwc, 24'h3);
		chk("width irq", {w_flag, w_irq}, 24'h3);
		chk("gated hold", cnt, 24'h3);
		pins(1'b0, 1'b0);
		sig_pol <= 1'b0;
		setup(measurement_timer_pkg::MODE_PERIOD_DUTY, 1'b0);
		pins(1'b1, 1'b0);
		chk("pd arm", cnt, 24'h1);
		ticks(3);
		pins(1'b0, 1'b0);
		chk("pd pwc", pwc, 24'h4);
		ticks(2);
		pins(1'b1, 1'b0);
		chk("pd prc", prc, 24'h6);
		chk("pd flags", {p_flag, p_irq, cnt}, {2'b11, 24'h1});
		chk("pd single", run, 24'h0);
		pins(1'b0, 1'b0);
		setup(measurement_timer_pkg::MODE_HIGH_LOW, 1'b1);
		pins(1'b1, 1'b0);
		ticks(3);
		pins(1'b0, 1'b0);
		chk("hl pwc", {pwc, cnt}, {24'h3, 24'h0});
		ticks(2);
		pins(1'b1, 1'b0);
		chk("hl prc", {prc, cnt}, {24'h2, 24'h0});
		ticks(1);
		chk("hl resume", cnt, 24'h1);
		pins(1'b0, 1'b0);
		setup(measurement_timer_pkg::MODE_WINDOWED, 1'b1);
		pins(1'b0, 1'b1);
		ticks(3);
		pins(1'b0, 1'b0);
		pins(1'b0, 1'b1);
		chk("win prc", {prc, cnt}, {24'h3, 24'h0});
		setup(measurement_timer_pkg::MODE_GATED_WINDOWED, 1'b1);
		pins(1'b1, 1'b0);
		ticks(2);
		pins(1'b0, 1'b0);
		ticks(2);
		pins(1'b1, 1'b1);
		ticks(3);
		pins(1'b0, 1'b1);
		ticks(2);
		chk("gw first", p_flag, 24'h0);
		pins(1'b0, 1'b0);
		pins(1'b0, 1'b1);
		chk("gw prc", {prc, cnt}, {24'h3, 24'h0});
		setup(measurement_timer_pkg::MODE_TIME_OF_FLIGHT, 1'b1);
		pins(1'b0, 1'b0);
		pins(1'b0, 1'b1);
		ticks(4);
		pins(1'b1, 1'b1);
		chk("tof prc", {prc, cnt}, {24'h4, 24'h0});
		pins(1'b0, 1'b0);
		pins(1'b0, 1'b1);
		ticks(2);
		pins(1'b0, 1'b0);
		chk("tof no pwc", w_flag, 24'h0);
		pins(1'b0, 1'b1);
		chk("tof pwc", {pwc, cnt}, {24'h2, 24'h0});
		pins(1'b0, 1'b0);
		setup(measurement_timer_pkg::MODE_CAPTURE, 1'b1);
		ticks(3);
		pins(1'b0, 1'b1);
		chk("cap prc", prc, 24'h3);
		ticks(2);
		pins(1'b0, 1'b0);
		chk("cap pwc", {pwc, cnt}, {24'h5, 24'h5});
		setup(measurement_timer_pkg::MODE_COUNTER, 1'b1);
		pulses(3, 1'b0);
		chk("cnt pulses", cnt, 24'h3);
		pins(1'b0, 1'b1);
		pins(1'b0, 1'b0);
		chk("cnt pwc", pwc, 24'h3);
		setup(measurement_timer_pkg::MODE_GATED_COUNTER, 1'b1);
		pulses(2, 1'b0);
		chk("gc gate", cnt, 24'h0);
		pins(1'b0, 1'b1);
		pulses(2, 1'b1);
		pins(1'b0, 1'b0);
		chk("gc pwc", pwc, 24'h2);
		setup(measurement_timer_pkg::MODE_WINDOWED_COUNTER, 1'b1);
		pins(1'b0, 1'b1);
		pulses(2, 1'b1);
		pins(1'b0, 1'b0);
		chk("wc pwc", pwc, 24'h2);
		pins(1'b0, 1'b1);
		chk("wc prc", prc, 24'h2);
		// Inverted window: pin low is the active level
		win_pol <= 1'b1;
		setup(measurement_timer_pkg::MODE_CAPTURE, 1'b1);
		chk("win status", ws, 24'h0);
		ticks(3);
		pins(1'b0, 1'b0);
		chk("inv prc", {prc, ws}, {24'h3, 1'b1});
		ticks(2);
		pins(1'b0, 1'b1);
		chk("inv pwc", {pwc, ws}, {24'h5, 1'b0});
		win_pol <= 1'b0;
		setup(measurement_timer_pkg::MODE_TIMER, 1'b1);
		ticks(2);
		hold = cnt;
		en <= 1'b0;
		ticks(3);
		chk("off cnt", cnt, hold);
		chk("off status", ts, 24'h0);
		chk("off flags", {w_flag, p_flag, m_flag}, 24'h0);
		conclude();
	end

	// Scenarios take well under 3000 clocks
	initial begin
		cyc(20000);
		num_errors++;
		conclude();
	end
endmodule // measurement_timer_tb_top
